/* common/asdp_regs.svh */
// Constants for the serial converter port: frame counts and reset-pin timing.
// Assumes a 125 MHz system clock on both ends.
`ifndef ASDP_REGS_SVH
`define ASDP_REGS_SVH

// -------------------------------------------------------------
// Frame
// -------------------------------------------------------------
`define ASDP_CMD_BITS        16
`define ASDP_RES_BITS        16
`define ASDP_CLK_PERIOD_NS   8
// -------------------------------------------------------------
// Reset pin timing
// -------------------------------------------------------------
`define ASDP_RST_MIN_NS      40
`define ASDP_RST_MAX_NS      100
`define ASDP_PD_MIN_NS       400
`define ASDP_PD_CYCLES       ((`ASDP_PD_MIN_NS + `ASDP_CLK_PERIOD_NS - 1) / `ASDP_CLK_PERIOD_NS)
`define ASDP_RST_HOST_CYCLES ((`ASDP_RST_MAX_NS) / `ASDP_CLK_PERIOD_NS)
// Internal conversion time in clk cycles; host serial half period is four times ASDP_HALF_SCLK clk cycles
`define ASDP_CONV_CYCLES     40
`define ASDP_HALF_SCLK       4
`define ASDP_RES_DEFAULT     16'h8000

`endif

/* common/asdp_pkg.sv */
// Types shared by both ends of the serial converter port.
// Assumes asdp_regs.svh is available on the include path.
package asdp_pkg;
    typedef enum logic [1:0] {ASDP_IDLE, ASDP_RUN, ASDP_ABORT, ASDP_PDOWN} asdp_mode_t;
endpackage

/* common/asdp_if.sv */
// Link between host controller and converter port.
// Assumes the port holds the output wire low whenever its enable is low.
`timescale 1ns/1ns
`default_nettype none
interface asdp_if;
    logic selectN;
    logic sclk;
    logic cmdLine;
    logic serOut;
    logic serOutEn;
    logic chainIn;
    logic resetPinN;
    modport dev  (input selectN, sclk, cmdLine, chainIn, resetPinN, output serOut, serOutEn);
    modport host (output selectN, sclk, cmdLine, resetPinN, input serOut, serOutEn);
endinterface
`default_nettype wire

/* rtl/asdp_sync3.sv */
// Three-stage pin synchroniser; a change counts once stages two and three agree.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module asdp_sync3 #(
    parameter logic INIT = 1'b1
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;

    always_comb begin
        next_stage = {stage[1:0], pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stage <= {3{INIT}};
            level <= INIT;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule
`default_nettype wire

/* rtl/asdp_device.sv */
// Converter end of the serial port: frame control, command capture, result shift.
// Assumes the link clock and pins are asynchronous and sampled by clk.
`timescale 1ns/1ns
`include "asdp_regs.svh"
`default_nettype none
module asdp_device
    import asdp_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    asdp_if.dev                            link,
    input  wire logic [`ASDP_RES_BITS-1:0] sampleValue,
    output logic                           sampleStrobe,
    output logic [`ASDP_CMD_BITS-1:0]      activeCmd,
    output logic                           cmdValid,
    output logic                           poweredDown
);
    // -------------------------------------------------------------
    // Pin sampling
    // -------------------------------------------------------------
    logic selN;
    logic sclkS;
    logic cmdS;
    logic chainS;
    logic rstPinS;

    asdp_sync3 #(.INIT(1'b1)) syncSel (.clk(clk), .reset(reset), .pin(link.selectN), .level(selN));
    asdp_sync3 #(.INIT(1'b1)) syncClk (.clk(clk), .reset(reset), .pin(link.sclk), .level(sclkS));
    asdp_sync3 #(.INIT(1'b0)) syncCmd (.clk(clk), .reset(reset), .pin(link.cmdLine), .level(cmdS));
    asdp_sync3 #(.INIT(1'b0)) syncChn (.clk(clk), .reset(reset), .pin(link.chainIn), .level(chainS));
    asdp_sync3 #(.INIT(1'b1)) syncRst (.clk(clk), .reset(reset), .pin(link.resetPinN),
                                       .level(rstPinS));

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    asdp_mode_t                mode;
    asdp_mode_t                next_mode;
    logic                      selD;
    logic                      sclkD;
    logic [5:0]                edgeCnt;
    logic [5:0]                next_edgeCnt;
    logic [`ASDP_CMD_BITS-1:0] cmdShift;
    logic [`ASDP_CMD_BITS-1:0] next_cmdShift;
    logic [`ASDP_CMD_BITS-1:0] next_activeCmd;
    logic                      next_cmdValid;
    logic [`ASDP_RES_BITS-1:0] resShift;
    logic [`ASDP_RES_BITS-1:0] next_resShift;
    logic [`ASDP_CMD_BITS-1:0] pendCmd;
    logic [`ASDP_CMD_BITS-1:0] next_pendCmd;
    logic                      pendValid;
    logic                      next_pendValid;
    logic [7:0]                convCnt;
    logic [7:0]                next_convCnt;
    logic [`ASDP_RES_BITS-1:0] convData;
    logic [`ASDP_RES_BITS-1:0] next_convData;
    logic [7:0]                lowCnt;
    logic [7:0]                next_lowCnt;
    logic                      outBit;
    logic                      next_outBit;
    logic                      outEn;
    logic                      next_outEn;
    logic                      next_sampleStrobe;

    logic selFall;
    logic selRise;
    logic sclkFall;
    logic sclkRise;
    logic pinLow;
    logic pdHit;

    assign selFall  = selD & ~selN;
    assign selRise  = ~selD & selN;
    assign sclkFall = sclkD & ~sclkS;
    assign sclkRise = ~sclkD & sclkS;
    assign pinLow   = ~rstPinS;
    // Power-down once the pin has stayed low for the long-pulse time
    assign pdHit    = pinLow && (lowCnt >= 8'(`ASDP_PD_CYCLES - 1));

    assign link.serOut   = outBit;
    assign link.serOutEn = outEn;
    assign poweredDown   = (mode == ASDP_PDOWN);

    always_comb begin
        next_mode         = mode;
        next_edgeCnt      = edgeCnt;
        next_cmdShift     = cmdShift;
        next_activeCmd    = activeCmd;
        next_cmdValid     = cmdValid;
        next_resShift     = resShift;
        next_pendCmd      = pendCmd;
        next_pendValid    = pendValid;
        next_convCnt      = convCnt;
        next_convData     = convData;
        next_outBit       = outBit;
        next_outEn        = outEn;
        next_sampleStrobe = 1'b0;
        next_lowCnt       = pinLow ? ((lowCnt == 8'hff) ? lowCnt : lowCnt + 8'h01) : 8'h00;

        if (pinLow) begin
            // Pin acts whatever the link is doing; control and output registers go to defaults, shift and data registers keep their values
            next_activeCmd = '0;
            next_cmdValid  = 1'b0;
            next_pendValid = 1'b0;
            next_outEn     = 1'b0;
            next_outBit    = 1'b0;
            next_edgeCnt   = '0;
            next_convCnt   = '0;
            if (pdHit) begin
                next_mode = ASDP_PDOWN;
            end else if (mode != ASDP_PDOWN) begin
                next_mode = ASDP_IDLE;
            end
        end else if (mode == ASDP_PDOWN) begin
            // Link ignored until the pin is released; wakes idle with defaults
            next_mode = ASDP_IDLE;
        end else begin
            if (convCnt != 8'h00) begin
                // Conversion timed on clk, not on the link clock
                next_convCnt = convCnt - 8'h01;
                if (convCnt == 8'h01) begin
                    next_resShift = convData;
                end
            end
            if (selFall) begin
                next_outEn   = 1'b1;
                next_outBit  = 1'b0;
                next_edgeCnt = '0;
                if (pendValid) begin
                    next_activeCmd = pendCmd;
                    next_cmdValid  = 1'b1;
                    next_pendValid = 1'b0;
                    next_mode      = ASDP_RUN;
                end
                if (next_mode == ASDP_RUN) begin
                    next_sampleStrobe = 1'b1;
                    next_convData     = sampleValue;
                    next_convCnt      = 8'(`ASDP_CONV_CYCLES);
                end
                next_resShift = '0;
            end else if (selRise) begin
                next_outEn  = 1'b0;
                next_outBit = 1'b0;
                if (edgeCnt < 6'd16) begin
                    next_mode     = ASDP_ABORT;
                    next_cmdValid = 1'b0;
                end
            end else if (!selN && sclkFall) begin
                next_edgeCnt = (edgeCnt == 6'h3f) ? edgeCnt : edgeCnt + 6'h01;
                if (edgeCnt < 6'd16) begin
                    next_cmdShift = {cmdShift[`ASDP_CMD_BITS-2:0], cmdS};
                end
                if (edgeCnt == 6'd15) begin
                    next_pendCmd   = {cmdShift[`ASDP_CMD_BITS-2:0], cmdS};
                    next_pendValid = 1'b1;
                    // Aborted or idle ports present a zero first bit, then the chain input directly
                    next_outBit    = (mode == ASDP_RUN) ? resShift[`ASDP_RES_BITS-1] : 1'b0;
                    next_resShift  = {resShift[`ASDP_RES_BITS-2:0], chainS};
                end else if (edgeCnt > 6'd15) begin
                    // Zeros from a grounded chain input give the trailing zeros
                    next_outBit   = (mode == ASDP_RUN) ? resShift[`ASDP_RES_BITS-1] : chainS;
                    next_resShift = {resShift[`ASDP_RES_BITS-2:0], chainS};
                end else begin
                    next_outBit = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode         <= ASDP_IDLE;
            selD         <= 1'b1;
            sclkD        <= 1'b1;
            edgeCnt      <= '0;
            cmdShift     <= '0;
            activeCmd    <= '0;
            cmdValid     <= 1'b0;
            resShift     <= '0;
            pendCmd      <= '0;
            pendValid    <= 1'b0;
            convCnt      <= '0;
            convData     <= '0;
            lowCnt       <= '0;
            outBit       <= 1'b0;
            outEn        <= 1'b0;
            sampleStrobe <= 1'b0;
        end else begin
            mode         <= next_mode;
            selD         <= selN;
            sclkD        <= sclkS;
            edgeCnt      <= next_edgeCnt;
            cmdShift     <= next_cmdShift;
            activeCmd    <= next_activeCmd;
            cmdValid     <= next_cmdValid;
            resShift     <= next_resShift;
            pendCmd      <= next_pendCmd;
            pendValid    <= next_pendValid;
            convCnt      <= next_convCnt;
            convData     <= next_convData;
            lowCnt       <= next_lowCnt;
            outBit       <= next_outBit;
            outEn        <= next_outEn;
            sampleStrobe <= next_sampleStrobe;
        end
    end

    // Rise of sclk is only tracked for edge detection
    logic unusedRise;
    assign unusedRise = sclkRise;
endmodule
`default_nettype wire

/* rtl/asdp_host.sv */
// Host end: drives select, serial clock by divider, command, reset pin; collects words.
// Assumes the device end sits across asdp_if.
`timescale 1ns/1ns
`include "asdp_regs.svh"
`default_nettype none
module asdp_host
    import asdp_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    asdp_if.host                           link,
    input  wire logic                      start,
    input  wire logic [`ASDP_CMD_BITS-1:0] cmdWord,
    input  wire logic [3:0]                chainLen,
    input  wire logic                      pulseReset,
    output logic                           busy,
    output logic                           wordValid,
    output logic [`ASDP_RES_BITS-1:0]      wordData
);
    typedef enum logic [1:0] {H_IDLE, H_FRAME, H_RSTP} asdp_hstate_t;

    asdp_hstate_t              st;
    asdp_hstate_t              next_st;
    logic [7:0]                div;
    logic [7:0]                next_div;
    logic [7:0]                edges;
    logic [7:0]                next_edges;
    logic [7:0]                total;
    logic [7:0]                next_total;
    logic [`ASDP_CMD_BITS-1:0] cmd;
    logic [`ASDP_CMD_BITS-1:0] next_cmd;
    logic [`ASDP_RES_BITS-1:0] rx;
    logic [`ASDP_RES_BITS-1:0] next_rx;
    logic                      sclk;
    logic                      next_sclk;
    logic                      sel;
    logic                      next_sel;
    logic                      rstN;
    logic                      next_rstN;
    logic                      next_wordValid;
    logic [`ASDP_RES_BITS-1:0] next_wordData;

    assign link.selectN   = sel;
    assign link.sclk      = sclk;
    assign link.cmdLine   = cmd[`ASDP_CMD_BITS-1];
    assign link.resetPinN = rstN;
    assign busy           = (st != H_IDLE);

    always_comb begin
        next_st        = st;
        next_div       = div;
        next_edges     = edges;
        next_total     = total;
        next_cmd       = cmd;
        next_rx        = rx;
        next_sclk      = sclk;
        next_sel       = sel;
        next_rstN      = rstN;
        next_wordValid = 1'b0;
        next_wordData  = wordData;
        case (st)
            H_IDLE: begin
                if (pulseReset) begin
                    next_rstN = 1'b0;
                    next_div  = 8'(`ASDP_RST_HOST_CYCLES); // Stays in the reset-only band
                    next_st   = H_RSTP;
                end else if (start) begin
                    // Only this host's select drops; with chainLen up to 14 every chained device is read in the one frame
                    next_sel   = 1'b0;
                    next_cmd   = cmdWord;
                    // 16 command edges plus 16 per chained device, for chainLen up to 14; at 15 the 8-bit total wraps to 0
                    next_total = 8'(`ASDP_CMD_BITS) + {chainLen, 4'h0};
                    next_edges = '0;
                    next_div   = 8'(`ASDP_HALF_SCLK * 4);
                    next_st    = H_FRAME;
                end
            end
            H_RSTP: begin
                next_div = div - 8'h01;
                if (div == 8'h01) begin
                    next_rstN = 1'b1;
                    next_st   = H_IDLE;
                end
            end
            H_FRAME: begin
                next_div = div - 8'h01;
                if (div == 8'h01) begin
                    next_div = 8'(`ASDP_HALF_SCLK * 4); // Slow clock lets conversion finish
                    if (edges == total) begin
                        next_sel  = 1'b1;
                        // Clock idles high so every frame starts alike
                        next_sclk = 1'b1;
                        next_st   = H_IDLE;
                    end else if (sclk) begin
                        next_sclk  = 1'b0;
                        next_edges = edges + 8'h01;
                        if (edges >= 8'd16) begin
                            // Bit launched one edge earlier is taken here
                            next_rx = {rx[`ASDP_RES_BITS-2:0], link.serOut};
                            if (edges[3:0] == 4'hf) begin
                                next_wordValid = 1'b1;
                                next_wordData  = {rx[`ASDP_RES_BITS-2:0], link.serOut};
                            end
                        end
                    end else begin
                        next_sclk = 1'b1;
                        if (edges != 8'h00) begin
                            next_cmd = {cmd[`ASDP_CMD_BITS-2:0], 1'b0};
                        end
                    end
                end
            end
            default: next_st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st        <= H_IDLE;
            div       <= '0;
            edges     <= '0;
            total     <= '0;
            cmd       <= '0;
            rx        <= '0;
            sclk      <= 1'b1;
            sel       <= 1'b1;
            rstN      <= 1'b1;
            wordValid <= 1'b0;
            wordData  <= '0;
        end else begin
            st        <= next_st;
            div       <= next_div;
            edges     <= next_edges;
            total     <= next_total;
            cmd       <= next_cmd;
            rx        <= next_rx;
            sclk      <= next_sclk;
            sel       <= next_sel;
            rstN      <= next_rstN;
            wordValid <= next_wordValid;
            wordData  <= next_wordData;
        end
    end
endmodule
`default_nettype wire

/* sim/asdp_sva.sv */
// Checker on the link between host and converter port.
// Assumes the bench instantiates it beside the link; one clock serves both ends.
`timescale 1ns/1ns
`default_nettype none
module asdp_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic selectN,
    input wire logic sclk,
    input wire logic cmdLine,
    input wire logic serOut,
    input wire logic serOutEn,
    input wire logic chainIn,
    input wire logic resetPinN
);
    logic       sclkQ;
    logic       sclkFall;
    logic       chainHigh;
    logic [7:0] fallCnt;
    logic [4:0] sinceFall;
    logic [4:0] idleCnt;

    assign sclkFall = sclkQ & ~sclk;

    // -----------------------------------------------------------------
    // Frame bookkeeping
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            sclkQ     <= 1'b1;
            chainHigh <= 1'b0;
            fallCnt   <= 8'h00;
            sinceFall <= 5'h1f;
            idleCnt   <= 5'h00;
        end else begin
            sclkQ     <= sclk;
            chainHigh <= !selectN && (chainHigh || chainIn);
            fallCnt   <= selectN ? 8'h00 : fallCnt + {7'h00, sclkFall};
            // Saturates so a long idle gap never wraps back into range
            sinceFall <= sclkFall ? 5'h00 : sinceFall + {4'h0, sinceFall != 5'h1f};
            // Deselected cycles so far; a counter instead of a long repetition
            idleCnt   <= selectN ? (idleCnt + {4'h0, idleCnt != 5'h1f}) : 5'h00;
        end
    end

    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_OUT_RELEASED: assert property (selectN [*8] |-> !serOutEn)
        else $error("output driven while select is high");
    AST_OUT_DRIVEN: assert property ($fell(selectN) |-> ##[1:8] serOutEn)
        else $error("output not driven after select fell");
    AST_LOW_IN_CMD: assert property (!selectN && serOutEn && fallCnt < 8'd16 |-> !serOut)
        else $error("output not low during command cycles");
    AST_ZERO_TAIL: assert property (!selectN && fallCnt > 8'd32 && !chainHigh |-> !serOut)
        else $error("output not zero after the result");
    AST_SCLK_IDLE: assert property (selectN && idleCnt >= 5'd19 |-> sclk)
        else $error("serial clock not idle high between frames");
    AST_CMD_STABLE: assert property (!sclk && !$past(sclk) |-> $stable(cmdLine))
        else $error("command line changed while the serial clock was low");
    AST_SCLK_HALF: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("serial clock low phase too short");
    AST_FRAME_EDGES: assert property ($rose(selectN) |-> fallCnt >= 8'd32 && fallCnt[3:0] == 4'h0)
        else $error("frame ended on a wrong edge count");
    AST_BIT_ON_FALL: assert property ($changed(serOut) && serOutEn && $past(serOutEn) && !selectN
        |-> sinceFall <= 5'd8)
        else $error("output changed away from a falling edge");
    AST_RESET_WIDTH: assert property ($fell(resetPinN) |-> !resetPinN [*6] ##[1:7] resetPinN)
        else $error("reset pulse width outside the short range");
endmodule
`default_nettype wire

/* sim/adc_serial_frame_daisy_port_tb.sv */
// Bench: host and converter port joined by one link, results checked against a queue model.
// Assumes asdp_regs.svh on the include path and one clock for both ends.
`timescale 1ns/1ns
`include "asdp_regs.svh"
`default_nettype none
module adc_serial_frame_daisy_port_tb;
    logic        clk         = 1'b0;
    logic        reset       = 1'b1;
    logic        start       = 1'b0;
    logic        pulseReset  = 1'b0;
    logic        chainDrv    = 1'b0;
    logic [3:0]  chainLen    = 4'h1;
    logic [15:0] cmdWord     = 16'h0000;
    logic [15:0] sampleValue = 16'h0000;
    logic        sampleStrobe;
    logic        cmdValid;
    logic        poweredDown;
    logic        busy;
    logic        wordValid;
    logic [15:0] activeCmd;
    logic [15:0] wordData;
    logic [15:0] lastCmd;
    logic [15:0] expQ[$];
    int          nMismatch   = 0;
    int          checks      = 0;
    int          cycles      = 0;
    int          strobes     = 0;

    asdp_if link ();
    // Stands for the output of an earlier device; driven to a random level each frame
    assign link.chainIn = chainDrv;

    asdp_device i_asdp_device (.clk(clk), .reset(reset), .link(link),
        .sampleValue(sampleValue), .sampleStrobe(sampleStrobe), .activeCmd(activeCmd),
        .cmdValid(cmdValid), .poweredDown(poweredDown));
    asdp_host i_asdp_host (.clk(clk), .reset(reset), .link(link), .start(start),
        .cmdWord(cmdWord), .chainLen(chainLen), .pulseReset(pulseReset), .busy(busy),
        .wordValid(wordValid), .wordData(wordData));
    asdp_sva i_asdp_sva (.clk(clk), .reset(reset), .selectN(link.selectN), .sclk(link.sclk),
        .cmdLine(link.cmdLine), .serOut(link.serOut), .serOutEn(link.serOutEn),
        .chainIn(link.chainIn), .resetPinN(link.resetPinN));

    always #4 clk = ~clk;

    // -----------------------------------------------------------------
    // Compare and verdict
    // -----------------------------------------------------------------
    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Word monitor and timeout
    // -----------------------------------------------------------------
    always @(negedge clk) begin
        cycles++;
        if (sampleStrobe === 1'b1) begin
            strobes++;
        end
        if (wordValid === 1'b1 && expQ.size() > 0) begin
            check_word("word", expQ.pop_front(), wordData);
        end
        if (cycles > 60000) begin
            nMismatch++;
            print_verdict();
        end
    end

    // -----------------------------------------------------------------
    // One frame with random command, sample, chain length and chain level
    // -----------------------------------------------------------------
    task automatic run_frame(input logic check, input logic expStrobe);
        int n;
        @(negedge clk);
        cmdWord     = 16'($urandom);
        sampleValue = 16'($urandom);
        chainLen    = 4'(1 + $urandom % 3);
        chainDrv    = 1'($urandom);
        strobes     = 0;
        start       = 1'b1;
        if (check) begin
            expQ.push_back(sampleValue);
            // A stand-alone end passes its chain level on after its own word
            for (n = 1; n < chainLen; n++) begin
                expQ.push_back({16{chainDrv}});
            end
        end
        @(negedge clk);
        start = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            // A frame that never ends counts against the run
            nMismatch++;
        end
        repeat (8) @(negedge clk);
        check_bit("strobe", expStrobe, strobes == 1);
        check_bit("drained", 1'b1, expQ.size() == 0);
        check_bit("cmdValid", expStrobe, cmdValid);
        expQ.delete();
    endtask

    initial begin
        void'($urandom(32'h006b4295));
        repeat (20) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        run_frame(1'b0, 1'b0);
        lastCmd = cmdWord;
        for (int i = 0; i < 6; i++) begin
            run_frame(1'b1, 1'b1);
            check_word("activeCmd", lastCmd, activeCmd);
            lastCmd = cmdWord;
        end
        @(negedge clk);
        pulseReset = 1'b1;
        @(negedge clk);
        pulseReset = 1'b0;
        repeat (40) @(negedge clk);
        check_bit("poweredDown", 1'b0, poweredDown);
        check_bit("cmdValid", 1'b0, cmdValid);
        run_frame(1'b0, 1'b0);
        run_frame(1'b1, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
